// *** design/deser_out_defs.svh ***
// Register offsets, field positions, reset values and codes for the output control block
`ifndef DESER_OUT_DEFS_SVH
`define DESER_OUT_DEFS_SVH

// Register offsets on the control bus
`define ADDR_CFG 8'h02
`define ADDR_CFG1 8'h03
`define ADDR_ALIAS 8'h08
`define ADDR_MODE 8'h09
`define ADDR_STATUS 8'h1c
`define ADDR_GPIO0 8'h1d
`define ADDR_GPIO12 8'h1e
`define ADDR_GPIO3_OUT4 8'h1f
`define ADDR_OUT56 8'h20
`define ADDR_OUT78 8'h21

// Reset values
`define RST_CFG 8'h00
`define RST_CFG1 8'h00
`define RST_ALIAS 8'h00
`define RST_MODE 8'h00
`define RST_GPIO 8'h00

// Configuration register fields
`define CFG_OUT_EN 7
`define CFG_PIN_OVR 6
`define CFG_OSS 4
`define CFG_LF_OVR 1
`define CFG_LF 0
`define CFG1_PASSTHRU 3
`define MODE_OVR_EN 4
`define MODE_AUDIO_I2S 5

// Nibble codes for GPIO lanes and register-driven outputs
`define NIB_GPIO_FWD 4'h5
`define NIB_GPIO_BCK 4'h3
`define NIB_OUT_HI 4'h9
`define NIB_OUT_LO 4'h1

// Low colour bits reused as GPIO lanes in 18-bit mode
`define GPIO0_BIT 16
`define GPIO1_BIT 17
`define GPIO2_BIT 8
`define GPIO3_BIT 9

// Strap decode
`define NUM_MODES 4'ha
`define STRAP_SETTLE 2'h2

`endif

// *** design/deser_out_pkg.sv ***
// Types shared by the output control block and its surroundings
package deser_out_pkg;

  // Control bus request, one cycle per access
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // Status carried in by the forward channel
  typedef struct packed {
    logic cdr_locked;
    logic link_active;
    logic mode18;
    logic [3:0] gpio;
  } fwd_link_s;

  // State sent out on the back channel
  typedef struct packed {
    logic irq_n;
    logic irq_fall;
    logic [3:0] gpio;
  } back_link_s;

  typedef enum logic {LOCK_ACQUIRE, LOCK_HELD} lock_state_e;

  // Ten strap configuration modes, in strap code order
  typedef enum logic [3:0] {
    MODE_NORMAL,
    MODE_LF,
    MODE_BACKCOMPAT,
    MODE_BACKCOMPAT_LF,
    MODE_REPEATER,
    MODE_REPEATER_LF,
    MODE_I2S_B,
    MODE_I2S_B_LF,
    MODE_I2S_B_REPEATER,
    MODE_I2S_B_REPEATER_LF
  } cfg_mode_e;

endpackage

// *** design/deser_output_gpio_control.sv ***
// Output-side control of a link deserializer: irq forward, GPIO lanes, outputs
//
// Overview of operation
// - Low downstream irq input is carried over the back channel.
// - In 18-bit mode low red and green bits become four GPIO lanes.
// - 18-bit mode is loaded from the serializer, no local write needed.
// - Device nibble 0x5 means forward output, 0x3 means back-channel input.
// - GPIO0 at 0x1D, GPIO1/2 low/high of 0x1E, GPIO3 low of 0x1F.
// - Five register outputs are driven only from local register bits.
// - Writing 0x90 to 0x21 drives the highest register output high.
// - Outputs 8..4 sit in 0x21, 0x20, 0x1F; nibble 9 high, 1 low.
// - After power-up the lock pin is off or low per output enable.
// - Lock goes high once lock completes; data and clock valid.
// - Output state follows power-down, output enable and sleep select.
// - Low frequency mode selects 5 to below 15 MHz, else 15 to 85.
// - Strap input decodes to ten modes; a register can replace it.
// - At most two repeater levels, three transmitters per receiver.
// - Repeater control bus passes through and supports target aliases.
// - Repeater supplies video and either packetized or serial audio.
// - Override bit 1 of 0x02 takes low frequency mode from bit 0.
`timescale 1ns/10ps
`include "deser_out_defs.svh"
module deser_output_gpio_control
  import deser_out_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire reg_req_s i_reg_req,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  input wire fwd_link_s i_fwd,
  output back_link_s o_bck,
  input wire logic [23:0] i_rgb,
  input wire logic i_downstream_irq_in_n,
  input wire logic [3:0] i_gpio_pin,
  input wire logic i_oen_pin,
  input wire logic i_output_sleep_state_select_pin,
  input wire logic [3:0] i_strap_mode_select,
  output logic o_lock,
  output logic o_lock_oe,
  output logic [23:0] o_rgb,
  output logic [23:0] o_rgb_oe,
  output logic o_pclk_en,
  output logic o_pclk_oe,
  output logic [4:0] o_reg_out,
  output logic [4:0] o_reg_out_oe,
  output logic o_low_freq_mode,
  output logic o_repeater_mode,
  output logic o_i2c_passthru,
  output logic [6:0] o_target_alias,
  output logic o_rpt_audio_i2s
);

  localparam int GPIO_BIT [4] = '{`GPIO0_BIT, `GPIO1_BIT, `GPIO2_BIT, `GPIO3_BIT};

  // Register file
  logic [7:0] cfg_r, cfg_nxt;
  logic [7:0] cfg1_r, cfg1_nxt;
  logic [7:0] alias_r, alias_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic [7:0] gpio0_r, gpio0_nxt;
  logic [7:0] gpio12_r, gpio12_nxt;
  logic [7:0] gpio3o4_r, gpio3o4_nxt;
  logic [7:0] out56_r, out56_nxt;
  logic [7:0] out78_r, out78_nxt;
  logic [7:0] rdata_nxt;
  logic [7:0] status_w;

  // Lock and mode state
  lock_state_e state_r, state_nxt;
  cfg_mode_e strap_mode_r, strap_mode_nxt;
  logic [1:0] strap_cnt_r, strap_cnt_nxt;
  logic mode18_r, mode18_nxt;
  logic lf_nxt;

  // Output next values
  logic lock_nxt, lock_oe_nxt;
  logic [23:0] rgb_nxt, rgb_oe_nxt;
  logic pclk_en_nxt, pclk_oe_nxt;
  logic [4:0] reg_out_nxt, reg_out_oe_nxt;
  back_link_s bck_nxt;
  logic repeater_nxt;

  // Synchronised pins
  logic [10:0] pins_s;
  logic irq_s;
  logic [3:0] gpio_s;
  logic oen_s, oss_s;
  logic [3:0] strap_s;

  // Derived levels
  cfg_mode_e mode_eff;
  logic oen_eff, oss_eff, locked, valid;
  logic [3:0] gnib [4];
  logic [3:0] onib [5];

  // Every pin passes two flops before any logic reads it
  // Enables reset low so nothing is driven while the pins settle; irq resets idle high
  pin_sync #(.W(11), .RST_VAL(11'h7cf)) u_pin_sync (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async({i_downstream_irq_in_n, i_gpio_pin, i_oen_pin, i_output_sleep_state_select_pin,
              i_strap_mode_select}),
    .o_sync(pins_s)
  );

  assign {irq_s, gpio_s, oen_s, oss_s, strap_s} = pins_s;

  // Lane nibbles: GPIO0 low of 0x1D, GPIO1/2 in 0x1E, GPIO3 low of 0x1F
  assign gnib[0] = gpio0_r[3:0];
  assign gnib[1] = gpio12_r[3:0];
  assign gnib[2] = gpio12_r[7:4];
  assign gnib[3] = gpio3o4_r[3:0];
  // Output 4 high of 0x1F, 5/6 in 0x20, 7/8 in 0x21
  assign onib[0] = gpio3o4_r[7:4];
  assign onib[1] = out56_r[3:0];
  assign onib[2] = out56_r[7:4];
  assign onib[3] = out78_r[3:0];
  assign onib[4] = out78_r[7:4];

  function automatic cfg_mode_e decode_mode(input logic [3:0] code);
    // Codes past the last mode fall back to normal operation
    decode_mode = (code < `NUM_MODES) ? cfg_mode_e'(code) : MODE_NORMAL;
  endfunction

  function automatic logic mode_is_lf(input cfg_mode_e m);
    case (m)
      MODE_LF, MODE_BACKCOMPAT_LF, MODE_REPEATER_LF, MODE_I2S_B_LF,
      MODE_I2S_B_REPEATER_LF: mode_is_lf = 1'b1;
      default: mode_is_lf = 1'b0;
    endcase
  endfunction

  function automatic logic mode_is_rpt(input cfg_mode_e m);
    case (m)
      MODE_REPEATER, MODE_REPEATER_LF, MODE_I2S_B_REPEATER,
      MODE_I2S_B_REPEATER_LF: mode_is_rpt = 1'b1;
      default: mode_is_rpt = 1'b0;
    endcase
  endfunction

  // Register override replaces the strap mode when enabled
  assign mode_eff = mode_r[`MODE_OVR_EN] ? decode_mode(mode_r[3:0]) : strap_mode_r;
  // Pin or register source for output enable and sleep select
  assign oen_eff = cfg_r[`CFG_PIN_OVR] ? cfg_r[`CFG_OUT_EN] : oen_s;
  assign oss_eff = cfg_r[`CFG_PIN_OVR] ? cfg_r[`CFG_OSS] : oss_s;
  assign locked = (state_r == LOCK_HELD);
  assign valid = oen_eff & oss_eff & locked & i_fwd.link_active;
  assign status_w = {locked, mode18_r, o_bck.irq_n, o_low_freq_mode, gpio_s};

  // Register writes and registered read answer
  always_comb
  begin
    cfg_nxt = cfg_r;
    cfg1_nxt = cfg1_r;
    alias_nxt = alias_r;
    mode_nxt = mode_r;
    gpio0_nxt = gpio0_r;
    gpio12_nxt = gpio12_r;
    gpio3o4_nxt = gpio3o4_r;
    out56_nxt = out56_r;
    out78_nxt = out78_r;
    rdata_nxt = 8'h00;
    if (i_reg_req.wr)
    begin
      case (i_reg_req.addr)
        `ADDR_CFG: cfg_nxt = i_reg_req.wdata;
        `ADDR_CFG1: cfg1_nxt = i_reg_req.wdata;
        `ADDR_ALIAS: alias_nxt = i_reg_req.wdata;
        `ADDR_MODE: mode_nxt = i_reg_req.wdata;
        `ADDR_GPIO0: gpio0_nxt = i_reg_req.wdata;
        `ADDR_GPIO12: gpio12_nxt = i_reg_req.wdata;
        `ADDR_GPIO3_OUT4: gpio3o4_nxt = i_reg_req.wdata;
        `ADDR_OUT56: out56_nxt = i_reg_req.wdata;
        `ADDR_OUT78: out78_nxt = i_reg_req.wdata; // 0x90 drives output 8 high
        default: cfg_nxt = cfg_r;
      endcase
    end
    if (i_reg_req.rd)
    begin
      case (i_reg_req.addr)
        `ADDR_CFG: rdata_nxt = cfg_r;
        `ADDR_CFG1: rdata_nxt = cfg1_r;
        `ADDR_ALIAS: rdata_nxt = alias_r;
        `ADDR_MODE: rdata_nxt = mode_r;
        `ADDR_STATUS: rdata_nxt = status_w;
        `ADDR_GPIO0: rdata_nxt = gpio0_r;
        `ADDR_GPIO12: rdata_nxt = gpio12_r;
        `ADDR_GPIO3_OUT4: rdata_nxt = gpio3o4_r;
        `ADDR_OUT56: rdata_nxt = out56_r;
        `ADDR_OUT78: rdata_nxt = out78_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cfg_r <= `RST_CFG;
      cfg1_r <= `RST_CFG1;
      alias_r <= `RST_ALIAS;
      mode_r <= `RST_MODE;
      gpio0_r <= `RST_GPIO;
      gpio12_r <= `RST_GPIO;
      gpio3o4_r <= `RST_GPIO;
      out56_r <= `RST_GPIO;
      out78_r <= `RST_GPIO;
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      cfg1_r <= cfg1_nxt;
      alias_r <= alias_nxt;
      mode_r <= mode_nxt;
      gpio0_r <= gpio0_nxt;
      gpio12_r <= gpio12_nxt;
      gpio3o4_r <= gpio3o4_nxt;
      out56_r <= out56_nxt;
      out78_r <= out78_nxt;
      o_reg_rdata <= rdata_nxt;
      o_reg_rvalid <= i_reg_req.rd;
    end
  end

  // Lock sequence, strap capture and mode loading
  always_comb
  begin
    state_nxt = state_r;
    strap_cnt_nxt = strap_cnt_r;
    strap_mode_nxt = strap_mode_r;
    mode18_nxt = mode18_r;
    lf_nxt = o_low_freq_mode;
    // Strap is sampled once the synchroniser has filled after power-up
    if (strap_cnt_r != `STRAP_SETTLE)
      strap_cnt_nxt = strap_cnt_r + 2'h1;
    else if (strap_cnt_r == `STRAP_SETTLE && state_r == LOCK_ACQUIRE)
      strap_mode_nxt = decode_mode(strap_s);
    case (state_r)
      LOCK_ACQUIRE:
      begin
        // Range only changes while unlocked, so a change needs a relock
        lf_nxt = cfg_r[`CFG_LF_OVR] ? cfg_r[`CFG_LF] : mode_is_lf(mode_eff);
        if (i_fwd.cdr_locked && strap_cnt_r == `STRAP_SETTLE)
          state_nxt = LOCK_HELD;
      end
      LOCK_HELD:
      begin
        if (!i_fwd.cdr_locked)
          state_nxt = LOCK_ACQUIRE;
      end
      default: state_nxt = LOCK_ACQUIRE;
    endcase
    // 18-bit mode follows the serializer whenever the link is locked
    if (i_fwd.cdr_locked)
      mode18_nxt = i_fwd.mode18;
  end

  // Power-down reset returns everything here to the acquire state
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r <= LOCK_ACQUIRE;
      strap_cnt_r <= 2'h0;
      strap_mode_r <= MODE_NORMAL;
      mode18_r <= 1'b0;
      o_low_freq_mode <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      strap_cnt_r <= strap_cnt_nxt;
      strap_mode_r <= strap_mode_nxt;
      mode18_r <= mode18_nxt;
      o_low_freq_mode <= lf_nxt;
    end
  end

  // Pin output states, GPIO lanes, register outputs and back channel
  always_comb
  begin
    // Lock pin: off or low while acquiring, high once locked
    lock_nxt = locked;
    lock_oe_nxt = oen_eff | locked;
    // Data and clock: off without enable, low unless fully valid
    rgb_oe_nxt = {24{oen_eff}};
    rgb_nxt = valid ? i_rgb : 24'h000000;
    pclk_oe_nxt = oen_eff;
    pclk_en_nxt = valid;
    bck_nxt.gpio = 4'h0;
    for (int g = 0; g < 4; g++)
    begin
      if (mode18_r)
      begin
        // Lanes replace the low colour bits only in 18-bit mode
        if (gnib[g] == `NIB_GPIO_FWD)
          rgb_nxt[GPIO_BIT[g]] = valid & i_fwd.gpio[g];
        else if (gnib[g] == `NIB_GPIO_BCK)
        begin
          rgb_oe_nxt[GPIO_BIT[g]] = 1'b0;
          bck_nxt.gpio[g] = gpio_s[g];
        end
        else
          rgb_nxt[GPIO_BIT[g]] = 1'b0;
      end
    end
    // Register outputs never look at the link
    for (int k = 0; k < 5; k++)
    begin
      reg_out_oe_nxt[k] = (onib[k] == `NIB_OUT_HI) || (onib[k] == `NIB_OUT_LO);
      reg_out_nxt[k] = (onib[k] == `NIB_OUT_HI);
    end
    // Level forwarded as is; the fall pulse marks a new interrupt cycle
    bck_nxt.irq_n = irq_s;
    bck_nxt.irq_fall = o_bck.irq_n & ~irq_s;
    // Repeater fan-out is limited by board wiring, not by this logic
    repeater_nxt = mode_is_rpt(mode_eff);
  end

  // Reset leaves every pin undriven, matching power-down
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_lock <= 1'b0;
      o_lock_oe <= 1'b0;
      o_rgb <= 24'h000000;
      o_rgb_oe <= 24'h000000;
      o_pclk_en <= 1'b0;
      o_pclk_oe <= 1'b0;
      o_reg_out <= 5'h00;
      o_reg_out_oe <= 5'h00;
      o_bck <= '{irq_n: 1'b1, irq_fall: 1'b0, gpio: 4'h0};
      o_repeater_mode <= 1'b0;
      o_i2c_passthru <= 1'b0;
      o_target_alias <= 7'h00;
      o_rpt_audio_i2s <= 1'b0;
    end
    else
    begin
      o_lock <= lock_nxt;
      o_lock_oe <= lock_oe_nxt;
      o_rgb <= rgb_nxt;
      o_rgb_oe <= rgb_oe_nxt;
      o_pclk_en <= pclk_en_nxt;
      o_pclk_oe <= pclk_oe_nxt;
      o_reg_out <= reg_out_nxt;
      o_reg_out_oe <= reg_out_oe_nxt;
      o_bck <= bck_nxt;
      o_repeater_mode <= repeater_nxt;
      o_i2c_passthru <= cfg1_r[`CFG1_PASSTHRU];
      o_target_alias <= alias_r[7:1];
      o_rpt_audio_i2s <= repeater_nxt & mode_r[`MODE_AUDIO_I2S];
    end
  end

endmodule

// *** design/pin_sync.sv ***
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_nxt;

  // First stage feeds only the second stage
  always_comb
  begin
    meta_nxt = i_async;
    sync_nxt = meta_r;
  end

  // Both stages reset to each pin's idle level, so no false edge or enable follows reset
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_r <= RST_VAL;
      o_sync <= RST_VAL;
    end
    else
    begin
      meta_r <= meta_nxt;
      o_sync <= sync_nxt;
    end
  end

endmodule

// *** test/deser_out_chk_sva.sv ***
// Port-level property checker for the output control block
`timescale 1ns/10ps
module deser_out_chk
  import deser_out_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire reg_req_s i_reg_req,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire fwd_link_s i_fwd,
  input wire back_link_s o_bck,
  input wire logic [23:0] i_rgb,
  input wire logic i_downstream_irq_in_n,
  input wire logic o_lock,
  input wire logic o_lock_oe,
  input wire logic [23:0] o_rgb,
  input wire logic o_pclk_en,
  input wire logic [4:0] o_reg_out,
  input wire logic [4:0] o_reg_out_oe
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  // Read answers come exactly one cycle later, and only then
  property p_rd_answer;
    i_reg_req.rd |=> o_reg_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_idle;
    !i_reg_req.rd |=> !o_reg_rvalid && o_reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  // Three edges from pin to back channel; guard keeps reset values out of the past
  property p_irq_fwd;
    $past(i_rst_n, 3) && $past(i_rst_n, 2) && $past(i_rst_n)
      |-> o_bck.irq_n == $past(i_downstream_irq_in_n, 3);
  endproperty
  a_irq_fwd: assert property (p_irq_fwd) else $error("irq level not forwarded");
  property p_irq_fall;
    $fell(o_bck.irq_n) |-> o_bck.irq_fall ##1 !o_bck.irq_fall;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fall pulse wrong");
  property p_gpo_top;
    i_reg_req.wr && i_reg_req.addr == 8'h21 && i_reg_req.wdata == 8'h90
      |-> ##2 o_reg_out[4] && o_reg_out_oe[4];
  endproperty
  a_gpo_top: assert property (p_gpo_top) else $error("top output not high");
  property p_gpo_low;
    i_reg_req.wr && i_reg_req.addr == 8'h20 && i_reg_req.wdata[3:0] == 4'h1
      |-> ##2 o_reg_out_oe[1] && !o_reg_out[1];
  endproperty
  a_gpo_low: assert property (p_gpo_low) else $error("nibble one not low");
  // Register outputs may only move two edges after a local write
  property p_gpo_src;
    $changed(o_reg_out) || $changed(o_reg_out_oe) |-> $past(i_reg_req.wr, 2);
  endproperty
  a_gpo_src: assert property (p_gpo_src) else $error("output moved without write");
  property p_valid;
    o_pclk_en |-> o_lock && o_lock_oe && o_rgb[7:0] == $past(i_rgb[7:0]);
  endproperty
  a_valid: assert property (p_valid) else $error("valid data without lock");
  property p_hold_low;
    !o_pclk_en |-> o_rgb == 24'h0;
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("data not held low");
  property p_lock;
    ($past(i_rst_n, 4) && i_fwd.cdr_locked) ##1 i_fwd.cdr_locked [*2] |=> o_lock && o_lock_oe;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not reported");
  property p_unlock;
    !i_fwd.cdr_locked [*3] |=> !o_lock;
  endproperty
  a_unlock: assert property (p_unlock) else $error("lock high while acquiring");
endmodule

bind deser_output_gpio_control deser_out_chk u_chk (
  .i_mclk, .i_rst_n, .i_reg_req, .o_reg_rdata, .o_reg_rvalid, .i_fwd, .o_bck, .i_rgb,
  .i_downstream_irq_in_n, .o_lock, .o_lock_oe, .o_rgb, .o_pclk_en, .o_reg_out,
  .o_reg_out_oe
);

// *** test/deser_output_gpio_control_tb_top.sv ***
// Self-checking bench for the output control block and its link partner
`timescale 1ns/10ps
`define CHK(a, b) \
  begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module deser_output_gpio_control_tb_top
  import deser_out_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  reg_req_s req = '0;
  logic [23:0] rgb_in = 24'h0;
  logic irq_pin_n = 1'b1;
  logic [3:0] gpio_pin = 4'h0;
  logic oen_pin = 1'b0;
  logic oss_pin = 1'b0;
  logic [3:0] strap = 4'h0;
  logic ser_wr = 1'b0;
  logic [7:0] ser_addr = 8'h00;
  logic [7:0] ser_wdata = 8'h00;
  logic isr_rd = 1'b0;
  logic link_on = 1'b0;
  logic [3:0] ser_gpio = 4'h0;
  logic [7:0] rdata;
  logic rvalid, lock, lock_oe, pclk_en, pclk_oe, lf, rpt, pass, aud, link_irq_n;
  logic [23:0] rgb, rgb_oe;
  logic [4:0] gpo, gpo_oe;
  logic [6:0] alias_addr;
  fwd_link_s fwd;
  back_link_s bck;
  int n_fail = 0;
  int tests_run = 0;

  initial
  begin
    forever #20 mclk = ~mclk;
  end

  deser_output_gpio_control u_dut (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_reg_req(req), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_fwd(fwd), .o_bck(bck), .i_rgb(rgb_in),
    .i_downstream_irq_in_n(irq_pin_n), .i_gpio_pin(gpio_pin), .i_oen_pin(oen_pin),
    .i_output_sleep_state_select_pin(oss_pin), .i_strap_mode_select(strap), .o_lock(lock),
    .o_lock_oe(lock_oe), .o_rgb(rgb), .o_rgb_oe(rgb_oe), .o_pclk_en(pclk_en),
    .o_pclk_oe(pclk_oe), .o_reg_out(gpo), .o_reg_out_oe(gpo_oe), .o_low_freq_mode(lf),
    .o_repeater_mode(rpt), .o_i2c_passthru(pass), .o_target_alias(alias_addr),
    .o_rpt_audio_i2s(aud)
  );

  // Each part sits on its own control bus here, so addresses stay distinct
  ser_link_model u_ser (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_wr(ser_wr), .i_addr(ser_addr), .i_wdata(ser_wdata),
    .i_isr_rd(isr_rd), .i_link_on(link_on), .i_gpio(ser_gpio), .i_bck(bck), .o_fwd(fwd),
    .o_link_irq_out_n(link_irq_n)
  );

  // Wait whole cycles, then step past the edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, e)
  endtask

  task automatic ser_reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    ser_wr <= 1'b1;
    ser_addr <= a;
    ser_wdata <= d;
    @(posedge mclk);
    ser_wr <= 1'b0;
  endtask

  // Bounded wait on the lock pin; a hang shows as a mismatch
  task automatic wait_lock(input logic v);
    for (int k = 0; k < 60 && lock !== v; k++)
      cyc(1);
    `CHK(lock, v)
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #(40 * 20000);
    n_fail++;
    conclude();
  end

  initial
  begin
    cyc(1);
    `CHK(lock_oe, 1'b0)
    `CHK(rgb_oe, 24'h0)
    `CHK(bck.irq_n, 1'b1)
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    // Reset values, with 0x22 as an unmapped place
    for (int a = 8'h1d; a <= 8'h22; a++)
      reg_rd(a[7:0], 8'h00);
    `CHK(lock_oe, 1'b0)
    reg_wr(8'h21, 8'h90);
    cyc(1);
    `CHK(gpo[4], 1'b1)
    reg_wr(8'h1f, 8'h90);
    reg_wr(8'h20, 8'h19);
    reg_wr(8'h21, 8'h91);
    cyc(1);
    `CHK(gpo_oe, 5'h1f)
    `CHK(gpo, 5'h13)
    reg_rd(8'h20, 8'h19);
    reg_wr(8'h20, 8'h01);
    cyc(1);
    `CHK(gpo_oe, 5'h1b)
    `CHK(gpo, 5'h11)
    // Every strap code, plus one out of range
    for (int s = 0; s < 11; s++)
    begin
      @(posedge mclk);
      strap <= s[3:0];
      cyc(8);
      `CHK(rpt, s inside {4, 5, 8, 9})
      `CHK(lf, s inside {1, 3, 5, 7, 9})
    end
    reg_wr(8'h09, 8'h34);
    reg_wr(8'h03, 8'h08);
    reg_wr(8'h08, 8'ha5);
    cyc(3);
    `CHK(rpt, 1'b1)
    `CHK(aud, 1'b1)
    `CHK(pass, 1'b1)
    `CHK(alias_addr, 7'h52)
    reg_wr(8'h02, 8'h03);
    cyc(3);
    `CHK(lf, 1'b1)
    // Power-down reset after a mode change clears the override
    @(posedge mclk);
    rst_n <= 1'b0;
    cyc(2);
    `CHK(gpo_oe, 5'h00)
    @(posedge mclk);
    rst_n <= 1'b1;
    cyc(4);
    `CHK(lf, 1'b0)
    @(posedge mclk);
    oen_pin <= 1'b1;
    oss_pin <= 1'b1;
    cyc(4);
    `CHK(lock_oe, 1'b1)
    `CHK(lock, 1'b0)
    ser_reg_wr(8'hc6, 8'h21);
    ser_reg_wr(8'h12, 8'h04);
    @(posedge mclk);
    link_on <= 1'b1;
    wait_lock(1'b1);
    @(posedge mclk);
    rgb_in <= 24'h5a3c96;
    cyc(3);
    `CHK(rgb[7:0], 8'h96)
    `CHK(pclk_en, 1'b1)
    `CHK(rgb_oe[7:0], 8'hff)
    reg_wr(8'h02, 8'h40);
    cyc(3);
    `CHK(rgb_oe, 24'h0)
    `CHK(pclk_oe, 1'b0)
    reg_wr(8'h02, 8'hc0);
    cyc(3);
    `CHK(rgb, 24'h0)
    reg_wr(8'h02, 8'h00);
    // Lanes 0,1 forward, lanes 2,3 back, two patterns each
    reg_wr(8'h1d, 8'h95);
    reg_wr(8'h1e, 8'h35);
    reg_wr(8'h1f, 8'h93);
    for (int p = 0; p < 2; p++)
    begin
      @(posedge mclk);
      ser_gpio <= p ? 4'h1 : 4'h2;
      gpio_pin <= p ? 4'h8 : 4'h4;
      cyc(6);
      `CHK(rgb[17:16], p ? 2'b01 : 2'b10)
      `CHK(bck.gpio[3:2], p ? 2'b10 : 2'b01)
      `CHK(rgb_oe[9:8], 2'b00)
    end
    // Interrupt cycle: forward, clear at partner, re-arm on next fall
    @(posedge mclk);
    irq_pin_n <= 1'b0;
    for (int k = 0; k < 20 && link_irq_n !== 1'b0; k++)
      cyc(1);
    `CHK(link_irq_n, 1'b0)
    @(posedge mclk);
    isr_rd <= 1'b1;
    @(posedge mclk);
    isr_rd <= 1'b0;
    cyc(6);
    `CHK(link_irq_n, 1'b1)
    @(posedge mclk);
    irq_pin_n <= 1'b1;
    cyc(4);
    @(posedge mclk);
    irq_pin_n <= 1'b0;
    cyc(6);
    `CHK(link_irq_n, 1'b0)
    @(posedge mclk);
    link_on <= 1'b0;
    wait_lock(1'b0);
    // Let the unlock property see three idle link cycles before the end
    cyc(4);
    conclude();
  end
endmodule

// *** test/ser_link_model.sv ***
// Behavioural model of the paired serializer at the far end of the link
`timescale 1ns/10ps
module ser_link_model
  import deser_out_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_isr_rd,
  input wire logic i_link_on,
  input wire logic [3:0] i_gpio,
  input wire back_link_s i_bck,
  output fwd_link_s o_fwd,
  output logic o_link_irq_out_n
);
  logic [7:0] irq_ctl_r;
  logic [7:0] mode_r;
  logic pend_r;
  logic [3:0] junk_r;

  // Host registers and pending irq; a status read wins over a new fall
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      irq_ctl_r <= 8'h00;
      mode_r <= 8'h00;
      pend_r <= 1'b0;
      junk_r <= 4'h5;
    end
    else
    begin
      junk_r <= ~junk_r;
      if (i_wr && i_addr == 8'hc6)
        irq_ctl_r <= i_wdata;
      if (i_wr && i_addr == 8'h12)
        mode_r <= i_wdata;
      if (i_isr_rd)
        pend_r <= 1'b0;
      else if (i_bck.irq_fall && irq_ctl_r[5] && irq_ctl_r[0])
        pend_r <= 1'b1;
    end
  end

  // A link that is down shows a changing pattern, never a stale value
  assign o_fwd.cdr_locked = i_link_on;
  assign o_fwd.link_active = i_link_on;
  assign o_fwd.mode18 = i_link_on ? (mode_r == 8'h04) : junk_r[0];
  assign o_fwd.gpio = i_link_on ? i_gpio : junk_r;
  assign o_link_irq_out_n = !pend_r;
endmodule
